// ==== iof_cfg.svh ====
// Register indices, field positions, reset values and bus answers of the fault status bank.
`ifndef IOF_CFG_SVH
`define IOF_CFG_SVH
`define IOF_ADDR_W 12
`define IOF_IDX_FAULT_THR 10'h05b
`define IOF_IDX_FAULT_ACTION 10'h05c
`define IOF_IDX_WARN_THR 10'h05d
`define IOF_IDX_SUM_BYTE 10'h078
`define IOF_IDX_SUM_WORD 10'h079
`define IOF_IDX_IN_STATUS 10'h07c
`define IOF_IDX_CTRL 10'h080
`define IOF_EXP_MSB 15
`define IOF_EXP_LSB 11
`define IOF_MANT_MSB 10
`define IOF_FAULT_THR_RST 16'h00ff
`define IOF_WARN_THR_RST 16'h0019
`define IOF_FAULT_ACTION_VAL 8'hc0
`define IOF_CTRL_EN_BIT 0
`define IOF_CTRL_CLR_BIT 1
`define IOF_CTRL_RST 1'h1
`define IOF_IN_FAULT_BIT 1
`define IOF_IN_WARN_BIT 0
`define IOF_RESP_OKAY 2'h0
`define IOF_RESP_SLVERR 2'h2
`endif

// ==== iof_pkg.sv ====
// Types shared by the fault status bank and its bus front end.
package iof_pkg;
	typedef struct packed {
		logic awvalid;
		logic [11:0] awaddr;
		logic wvalid;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic bready;
		logic arvalid;
		logic [11:0] araddr;
		logic rready;
	} iof_axil_req_t;
	typedef struct packed {
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} iof_axil_rsp_t;
	typedef struct packed {
		logic output_overvoltage_flag;
		logic output_voltage_summary_flag_uv;
		logic output_overcurrent_flag;
		logic output_current_summary_flag_ocw;
		logic input_undervoltage_flag;
		logic ot_fault;
		logic ot_warn;
		logic comm_memory_logic_flag;
		logic vendor;
	} iof_raw_t;
	typedef struct packed {
		logic output_voltage_summary_flag_sum;
		logic output_current_summary_flag_sum;
		logic input_sum;
		logic vendor;
		logic output_overvoltage_flag;
		logic output_overcurrent_flag;
		logic input_undervoltage_flag;
		logic temp;
		logic comm_memory_logic_flag;
		logic other;
		logic iin_fault;
		logic iin_warn;
	} iof_flags_t;
	typedef enum logic [1:0] {
		IOF_WR_IDLE = 2'b00,
		IOF_WR_RESP = 2'b01
	} iof_wr_state_t;
endpackage

// ==== iof_axil_slave.sv ====
// AXI4-Lite slave front end: takes writes and reads and returns registered answers.
`timescale 1ns/1ps
module iof_axil_slave (
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire iof_pkg::iof_axil_req_t req_in,
	output iof_pkg::iof_axil_rsp_t rsp_out,
	output logic wr_en_out,
	output logic [11:0] wr_addr_out,
	output logic [31:0] wr_data_out,
	output logic [3:0] wr_strb_out,
	input wire logic wr_err_in,
	output logic [11:0] rd_addr_out,
	input wire logic [31:0] rd_data_in,
	input wire logic rd_err_in
);
	import iof_pkg::*;
	`include "iof_cfg.svh"
	logic aw_held_r, w_held_r, rd_pend_r;
	logic aw_nxt, w_nxt, b_nxt, rp_nxt, rv_nxt, wr_fire;
	iof_wr_state_t wst_r;

	assign wr_fire = aw_held_r & w_held_r & (wst_r == IOF_WR_IDLE);
	assign wr_en_out = wr_fire;

	always_comb begin
		aw_nxt = wr_fire ? 1'b0 : (aw_held_r | (req_in.awvalid & rsp_out.awready));
		w_nxt = wr_fire ? 1'b0 : (w_held_r | (req_in.wvalid & rsp_out.wready));
		b_nxt = wr_fire | (rsp_out.bvalid & ~req_in.bready);
		rp_nxt = req_in.arvalid & rsp_out.arready;
		rv_nxt = rd_pend_r | (rsp_out.rvalid & ~req_in.rready);
	end

	// Address and data are taken in either order; a new one waits until the answer is taken.
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			aw_held_r <= 1'b0;
			w_held_r <= 1'b0;
			wst_r <= IOF_WR_IDLE;
			wr_addr_out <= 12'h000;
			wr_data_out <= 32'h0000_0000;
			wr_strb_out <= 4'h0;
			rsp_out.awready <= 1'b0;
			rsp_out.wready <= 1'b0;
			rsp_out.bvalid <= 1'b0;
			rsp_out.bresp <= `IOF_RESP_OKAY;
			rd_pend_r <= 1'b0;
			rd_addr_out <= 12'h000;
			rsp_out.arready <= 1'b0;
			rsp_out.rvalid <= 1'b0;
			rsp_out.rdata <= 32'h0000_0000;
			rsp_out.rresp <= `IOF_RESP_OKAY;
		end else begin
			aw_held_r <= aw_nxt;
			w_held_r <= w_nxt;
			rsp_out.awready <= ~aw_nxt & ~b_nxt;
			rsp_out.wready <= ~w_nxt & ~b_nxt;
			rsp_out.bvalid <= b_nxt;
			if (req_in.awvalid && rsp_out.awready) begin
				wr_addr_out <= req_in.awaddr;
			end
			if (req_in.wvalid && rsp_out.wready) begin
				wr_data_out <= req_in.wdata;
				wr_strb_out <= req_in.wstrb;
			end
			case (wst_r)
				IOF_WR_IDLE: begin
					if (wr_fire) begin
						rsp_out.bresp <= wr_err_in ? `IOF_RESP_SLVERR : `IOF_RESP_OKAY;
						wst_r <= IOF_WR_RESP;
					end
				end
				IOF_WR_RESP: begin
					if (req_in.bready) begin
						wst_r <= IOF_WR_IDLE;
					end
				end
				default: begin
					wst_r <= IOF_WR_IDLE;
				end
			endcase
			// The read side shares this process because both sides write fields of one response variable.
			rd_pend_r <= rp_nxt;
			rsp_out.arready <= ~rp_nxt & ~rv_nxt;
			rsp_out.rvalid <= rv_nxt;
			if (rp_nxt) begin
				rd_addr_out <= req_in.araddr;
			end
			if (rd_pend_r) begin
				rsp_out.rdata <= rd_data_in;
				rsp_out.rresp <= rd_err_in ? `IOF_RESP_SLVERR : `IOF_RESP_OKAY;
			end
		end
	end
endmodule

// ==== iof_fault_status.sv ====
// Input overcurrent fault handling and fault summary registers behind an AXI4-Lite slave.
// What this block does
// - Current thresholds are linear: five-bit signed exponent above eleven-bit signed mantissa.
// - Input current above the fault threshold disables the output at once, latched off.
// - No automatic restart is attempted after an input overcurrent shutdown.
// - Output stays disabled until the fault is cleared.
// - Input fault sets status byte other flag, word input flag and input status bit.
// - Input fault asserts both the alert output and the regulator fault output.
// - Fault action register is read-only and reads c0h, latch-off without retry.
// - Warning threshold resets to 0019h, twenty-five amperes, and is writable.
// - Current above warning sets other, input and warning bits, asserting only alert.
// - Status byte reads the same storage as the status word low byte.
// - Every fault and warning raises alert except input undervoltage.
// - Status byte bit 7 always reads zero.
// - Status byte bit 6 is raw: one whenever the output is not powered.
// - Status byte bit 5 latches an output overvoltage fault.
// - Status byte bit 4 latches an output overcurrent fault.
// - Status byte bit 3 latches input below the undervoltage lockout threshold.
// - Status byte bit 2 latches any over-temperature fault or warning.
// - Status byte bit 1 latches a communication, memory or logic fault.
// - Status byte bit 0 latches any other fault or warning except the vendor flag.
// - Status word is sixteen bits, latched bits reset to zero, raw bits 11 and 6 do not, bits 10 to 8 read zero.
// - Status byte is eight bits; latched bits reset to zero, raw bit 6 reads one in reset.
// - Status word bit 13 latches any input voltage or current fault or warning.
// - Status word bit 11 is raw: one while the power good pin is low.
// - Status word bit 15 latches any output voltage fault or warning.
`timescale 1ns/1ps
module iof_fault_status (
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire iof_pkg::iof_axil_req_t axil_req_in,
	output iof_pkg::iof_axil_rsp_t axil_rsp_out,
	input wire logic [15:0] iin_meas_in,
	input wire logic iin_meas_valid_in,
	input wire iof_pkg::iof_raw_t raw_in,
	input wire logic power_good_pin_in,
	output logic output_enable_out,
	output logic alert_out,
	output logic regulator_fault_out
);
	import iof_pkg::*;
	`include "iof_cfg.svh"

	logic [15:0] fault_thr_r, warn_thr_r;
	logic ctrl_en_r, off_latch_r, off_latch_nxt;
	iof_flags_t flags_r, flags_set, flags_nxt;
	logic wr_en, wr_err, rd_err, clr_pulse;
	logic [11:0] wr_addr, rd_addr;
	logic [31:0] wr_data, rd_data;
	logic [3:0] wr_strb;
	logic iin_fault_now, iin_warn_now;
	logic [7:0] sum_byte, in_status;
	logic [15:0] sum_word;

	// Scales a linear value to signed fixed point with sixteen fraction bits.
	function automatic logic signed [47:0] lin_to_fix(input logic [15:0] v);
		logic signed [4:0] e;
		logic signed [47:0] x;
		e = v[`IOF_EXP_MSB:`IOF_EXP_LSB];
		x = {{37{v[`IOF_MANT_MSB]}}, v[`IOF_MANT_MSB:0]} <<< 16;
		if (e[4]) begin
			x = x >>> (5'(-e));
		end else begin
			x = x <<< e[3:0];
		end
		return x;
	endfunction

	function automatic logic at_idx(input logic [11:0] a, input logic [9:0] idx);
		return a == {idx, 2'b00};
	endfunction

	iof_axil_slave u_bus (
		.clk_in(clk_in),
		.rst_n_in(rst_n_in),
		.req_in(axil_req_in),
		.rsp_out(axil_rsp_out),
		.wr_en_out(wr_en),
		.wr_addr_out(wr_addr),
		.wr_data_out(wr_data),
		.wr_strb_out(wr_strb),
		.wr_err_in(wr_err),
		.rd_addr_out(rd_addr),
		.rd_data_in(rd_data),
		.rd_err_in(rd_err)
	);

	// Both limits are compared in the same linear scale as the measurement.
	assign iin_fault_now = iin_meas_valid_in & (lin_to_fix(iin_meas_in) > lin_to_fix(fault_thr_r));
	assign iin_warn_now = iin_meas_valid_in & (lin_to_fix(iin_meas_in) > lin_to_fix(warn_thr_r));

	assign clr_pulse = wr_en & at_idx(wr_addr, `IOF_IDX_CTRL) & wr_strb[0] & wr_data[`IOF_CTRL_CLR_BIT];

	always_comb begin
		if (at_idx(wr_addr, `IOF_IDX_FAULT_THR) || at_idx(wr_addr, `IOF_IDX_WARN_THR)) begin
			wr_err = 1'b0;
		end else if (at_idx(wr_addr, `IOF_IDX_CTRL)) begin
			wr_err = 1'b0;
		end else begin
			wr_err = 1'b1;
		end
	end

	// Thresholds take byte lanes 0 and 1; the upper lanes are ignored.
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			fault_thr_r <= `IOF_FAULT_THR_RST;
			warn_thr_r <= `IOF_WARN_THR_RST;
			ctrl_en_r <= `IOF_CTRL_RST;
		end else if (wr_en) begin
			if (at_idx(wr_addr, `IOF_IDX_FAULT_THR)) begin
				if (wr_strb[0]) fault_thr_r[7:0] <= wr_data[7:0];
				if (wr_strb[1]) fault_thr_r[15:8] <= wr_data[15:8];
			end else if (at_idx(wr_addr, `IOF_IDX_WARN_THR)) begin
				if (wr_strb[0]) warn_thr_r[7:0] <= wr_data[7:0];
				if (wr_strb[1]) warn_thr_r[15:8] <= wr_data[15:8];
			end else if (at_idx(wr_addr, `IOF_IDX_CTRL)) begin
				if (wr_strb[0]) ctrl_en_r <= wr_data[`IOF_CTRL_EN_BIT];
			end
		end
	end

	// A bad bus access counts as a communication fault.
	always_comb begin
		flags_set.output_voltage_summary_flag_sum = raw_in.output_overvoltage_flag | raw_in.output_voltage_summary_flag_uv;
		flags_set.output_current_summary_flag_sum = raw_in.output_overcurrent_flag | raw_in.output_current_summary_flag_ocw;
		flags_set.input_sum = iin_fault_now | iin_warn_now | raw_in.input_undervoltage_flag;
		flags_set.vendor = raw_in.vendor;
		flags_set.output_overvoltage_flag = raw_in.output_overvoltage_flag;
		flags_set.output_overcurrent_flag = raw_in.output_overcurrent_flag;
		flags_set.input_undervoltage_flag = raw_in.input_undervoltage_flag;
		flags_set.temp = raw_in.ot_fault | raw_in.ot_warn;
		flags_set.comm_memory_logic_flag = raw_in.comm_memory_logic_flag | (wr_en & wr_err) | (rd_err & axil_rsp_out.rvalid & axil_req_in.rready);
		flags_set.other = iin_fault_now | iin_warn_now | raw_in.output_voltage_summary_flag_uv | raw_in.output_current_summary_flag_ocw;
		flags_set.iin_fault = iin_fault_now;
		flags_set.iin_warn = iin_warn_now;
		// A new event in the clearing cycle stays set.
		flags_nxt = (clr_pulse ? '0 : flags_r) | flags_set;
		off_latch_nxt = iin_fault_now | (off_latch_r & ~clr_pulse);
	end

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			flags_r <= '0;
			off_latch_r <= 1'b0;
		end else begin
			flags_r <= flags_nxt;
			off_latch_r <= off_latch_nxt;
		end
	end

	// Alert ignores input undervoltage; only the input overcurrent fault drives the regulator fault pin.
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			output_enable_out <= 1'b0;
			alert_out <= 1'b0;
			regulator_fault_out <= 1'b0;
		end else begin
			output_enable_out <= ctrl_en_r & ~off_latch_nxt;
			alert_out <= |{flags_nxt.output_voltage_summary_flag_sum, flags_nxt.output_current_summary_flag_sum, flags_nxt.iin_fault, flags_nxt.iin_warn,
				flags_nxt.vendor, flags_nxt.temp, flags_nxt.comm_memory_logic_flag, flags_nxt.other};
			regulator_fault_out <= flags_nxt.iin_fault;
		end
	end

	// The byte is built once and reused as the word's low half.
	assign sum_byte = {1'b0, ~output_enable_out, flags_r.output_overvoltage_flag, flags_r.output_overcurrent_flag, flags_r.input_undervoltage_flag,
		flags_r.temp, flags_r.comm_memory_logic_flag, flags_r.other};
	assign sum_word = {flags_r.output_voltage_summary_flag_sum, flags_r.output_current_summary_flag_sum, flags_r.input_sum, flags_r.vendor,
		~power_good_pin_in, 3'h0, sum_byte};
	always_comb begin
		in_status = 8'h00;
		in_status[`IOF_IN_FAULT_BIT] = flags_r.iin_fault;
		in_status[`IOF_IN_WARN_BIT] = flags_r.iin_warn;
	end

	always_comb begin
		rd_err = 1'b0;
		if (at_idx(rd_addr, `IOF_IDX_FAULT_THR)) begin
			rd_data = {16'h0000, fault_thr_r};
		end else if (at_idx(rd_addr, `IOF_IDX_FAULT_ACTION)) begin
			rd_data = {24'h00_0000, `IOF_FAULT_ACTION_VAL};
		end else if (at_idx(rd_addr, `IOF_IDX_WARN_THR)) begin
			rd_data = {16'h0000, warn_thr_r};
		end else if (at_idx(rd_addr, `IOF_IDX_SUM_BYTE)) begin
			rd_data = {24'h00_0000, sum_byte};
		end else if (at_idx(rd_addr, `IOF_IDX_SUM_WORD)) begin
			rd_data = {16'h0000, sum_word};
		end else if (at_idx(rd_addr, `IOF_IDX_IN_STATUS)) begin
			rd_data = {24'h00_0000, in_status};
		end else if (at_idx(rd_addr, `IOF_IDX_CTRL)) begin
			rd_data = {31'h0000_0000, ctrl_en_r};
		end else begin
			rd_data = 32'h0000_0000;
			rd_err = 1'b1;
		end
	end

	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!rst_n_in);

	property p_thr_write;
		wr_en && at_idx(wr_addr, `IOF_IDX_WARN_THR) && wr_strb[1:0] == 2'h3 |=> warn_thr_r == $past(wr_data[15:0]);
	endproperty
	a_thr_write: assert property (p_thr_write) else $error("warning threshold write lost");

	property p_fault_off;
		iin_fault_now |=> !output_enable_out && off_latch_r;
	endproperty
	a_fault_off: assert property (p_fault_off) else $error("output still on after input fault");

	property p_stay_off;
		off_latch_r && !clr_pulse |=> off_latch_r && !output_enable_out;
	endproperty
	a_stay_off: assert property (p_stay_off) else $error("output restarted without clear");

	property p_fault_flags;
		iin_fault_now |=> sum_byte[0] && sum_word[13] && in_status[`IOF_IN_FAULT_BIT];
	endproperty
	a_fault_flags: assert property (p_fault_flags) else $error("input fault flags not set");

	property p_fault_notify;
		iin_fault_now |=> alert_out && regulator_fault_out;
	endproperty
	a_fault_notify: assert property (p_fault_notify) else $error("host not notified of input fault");

	property p_action_ro;
		at_idx(rd_addr, `IOF_IDX_FAULT_ACTION) |-> rd_data == 32'h0000_00c0 && !rd_err;
	endproperty
	a_action_ro: assert property (p_action_ro) else $error("fault action value wrong");

	property p_warn_only_alert;
		iin_warn_now && !iin_fault_now && !off_latch_r && !flags_r.iin_fault |=> alert_out && !regulator_fault_out
			&& in_status[`IOF_IN_WARN_BIT];
	endproperty
	a_warn_only_alert: assert property (p_warn_only_alert) else $error("warning response wrong");

	property p_byte_is_word;
		sum_word[7:0] == sum_byte && sum_word[10:8] == 3'h0 && !sum_byte[7];
	endproperty
	a_byte_is_word: assert property (p_byte_is_word) else $error("status byte and word disagree");

	property p_uv_no_alert;
		flags_nxt == 12'h220 |=> !alert_out && sum_byte[3];
	endproperty
	a_uv_no_alert: assert property (p_uv_no_alert) else $error("undervoltage raised alert");

	property p_off_raw;
		sum_byte[6] == !output_enable_out && sum_word[11] == !power_good_pin_in;
	endproperty
	a_off_raw: assert property (p_off_raw) else $error("raw status bits wrong");

	property p_sticky;
		flags_r.output_overvoltage_flag && !clr_pulse ##1 !clr_pulse |-> sum_byte[5] && sum_word[15];
	endproperty
	a_sticky: assert property (p_sticky) else $error("latched flag dropped");

	property p_regfault_only_iin;
		!flags_nxt.iin_fault |=> !regulator_fault_out;
	endproperty
	a_regfault_only_iin: assert property (p_regfault_only_iin) else $error("regulator fault without input fault");

	property p_temp_alert;
		raw_in.ot_warn |=> alert_out && sum_byte[2];
	endproperty
	a_temp_alert: assert property (p_temp_alert) else $error("temperature warning did not raise alert");

	c_fault: cover property (iin_fault_now ##1 regulator_fault_out);
	c_warn: cover property (iin_warn_now && !iin_fault_now ##1 alert_out && !regulator_fault_out);
	c_clear: cover property (off_latch_r && clr_pulse && !iin_fault_now ##1 output_enable_out);
	c_read_word: cover property (axil_rsp_out.rvalid && at_idx(rd_addr, `IOF_IDX_SUM_WORD) && sum_word[13]);
endmodule

// ==== iof_host.sv ====
// Host model: AXI4-Lite master that makes one register access at a time.
`timescale 1ns/1ps
module iof_host (
	input wire logic clk_in,
	output iof_pkg::iof_axil_req_t req_out,
	input wire iof_pkg::iof_axil_rsp_t rsp_in
);
	import iof_pkg::*;
	initial req_out = '0;
	// Released address and data lines show the inverse, so a stale value is never mistaken for a live one.
	task automatic wr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
		logic aw;
		logic w;
		aw = 1'b0;
		w = 1'b0;
		@(posedge clk_in);
		req_out.awaddr <= a;
		req_out.wdata <= d;
		req_out.wstrb <= 4'hf;
		req_out.awvalid <= 1'b1;
		req_out.wvalid <= 1'b1;
		req_out.bready <= 1'b1;
		while (!(aw && w)) begin
			@(posedge clk_in);
			if (!aw && rsp_in.awready) begin
				aw = 1'b1;
				req_out.awvalid <= 1'b0;
				req_out.awaddr <= ~a;
			end
			if (!w && rsp_in.wready) begin
				w = 1'b1;
				req_out.wvalid <= 1'b0;
				req_out.wdata <= ~d;
			end
		end
		while (!rsp_in.bvalid) @(posedge clk_in);
		r = rsp_in.bresp;
		req_out.bready <= 1'b0;
	endtask
	task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge clk_in);
		req_out.araddr <= a;
		req_out.arvalid <= 1'b1;
		req_out.rready <= 1'b1;
		do @(posedge clk_in); while (!rsp_in.arready);
		req_out.arvalid <= 1'b0;
		req_out.araddr <= ~a;
		while (!rsp_in.rvalid) @(posedge clk_in);
		d = rsp_in.rdata;
		r = rsp_in.rresp;
		req_out.rready <= 1'b0;
	endtask
endmodule

// ==== tb_top.sv ====
// Self-checking bench of the fault status bank against a small behavioural model.
`timescale 1ns/1ps
`include "iof_cfg.svh"
module tb_top;
	import iof_pkg::*;
	logic clk_in = 1'b0;
	logic rst_n_in = 1'b0;
	iof_axil_req_t req;
	iof_axil_rsp_t rsp;
	logic [15:0] meas = 16'h0000;
	logic meas_v = 1'b0;
	logic [8:0] rawv = 9'h000;
	logic pg = 1'b1;
	logic oe;
	logic al;
	logic rf;
	int n_errors = 0;
	int total_checks = 0;
	int cyc = 0;
	logic [31:0] rs = 32'd88;
	logic [31:0] d;
	logic [1:0] r;
	logic [15:0] m_word = 16'h0000;
	logic [15:0] m_in = 16'h0000;
	logic [15:0] wthr = `IOF_WARN_THR_RST;
	logic [15:0] fthr = `IOF_FAULT_THR_RST;
	logic m_al = 1'b0;
	logic m_rf = 1'b0;
	logic m_en = 1'b1;
	iof_fault_status uut (.clk_in(clk_in), .rst_n_in(rst_n_in), .axil_req_in(req), .axil_rsp_out(rsp),
		.iin_meas_in(meas), .iin_meas_valid_in(meas_v), .raw_in(iof_raw_t'(rawv)),
		.power_good_pin_in(pg), .output_enable_out(oe), .alert_out(al), .regulator_fault_out(rf));
	iof_host host (.clk_in(clk_in), .req_out(req), .rsp_in(rsp));
	initial forever #2 clk_in = ~clk_in;
	function automatic logic [11:0] ad(input logic [9:0] i);
		return {i, 2'b00};
	endfunction
	function automatic logic [31:0] rnd();
		rs = rs ^ (rs << 13);
		rs = rs ^ (rs >> 17);
		rs = rs ^ (rs << 5);
		return rs;
	endfunction
	// Linear value: signed exponent above signed mantissa.
	function automatic longint lin(input logic [15:0] v);
		longint m;
		int e;
		m = $signed(v[10:0]);
		e = $signed(v[15:11]);
		return (e >= 0) ? (m <<< e) : (m >>> (-e));
	endfunction
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		total_checks++;
		if (g !== e) begin
			n_errors++;
			$display("unexpected %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic ev(input logic [15:0] mask, input logic [15:0] inb, input logic a, input logic f);
		m_word |= mask;
		m_in |= inb;
		m_al |= a;
		m_rf |= f;
		if (f) m_en = 1'b0;
	endtask
	task automatic clear();
		host.wr(ad(`IOF_IDX_CTRL), 32'h3, r);
		m_word = 16'h0000;
		m_in = 16'h0000;
		m_al = 1'b0;
		m_rf = 1'b0;
		m_en = 1'b1;
	endtask
	task automatic check_all();
		#1;
		chk("enable", {31'd0, m_en}, {31'd0, oe});
		chk("alert", {31'd0, m_al}, {31'd0, al});
		chk("regfault", {31'd0, m_rf}, {31'd0, rf});
		host.rd(ad(`IOF_IDX_SUM_WORD), d, r);
		chk("word", {16'h0000, m_word | {4'h0, ~pg, 4'h0, ~m_en, 6'h00}}, d);
		host.rd(ad(`IOF_IDX_SUM_BYTE), d, r);
		chk("byte", {24'h0, m_word[7:0] | {1'b0, ~m_en, 6'h00}}, d);
		host.rd(ad(`IOF_IDX_IN_STATUS), d, r);
		chk("in_status", {16'h0000, m_in}, d);
	endtask
	task automatic pulse(input logic [15:0] v);
		@(posedge clk_in);
		meas <= v;
		meas_v <= 1'b1;
		@(posedge clk_in);
		meas_v <= 1'b0;
		if (lin(v) > lin(wthr)) ev(16'h2001, 16'h0001, 1'b1, 1'b0);
		if (lin(v) > lin(fthr)) ev(16'h2001, 16'h0002, 1'b1, 1'b1);
	endtask
	function automatic logic [15:0] raw_mask(input int i);
		case (i)
			0: return 16'h1000;
			1: return 16'h0002;
			2, 3: return 16'h0004;
			4: return 16'h2008;
			5: return 16'h4001;
			6: return 16'h4010;
			7: return 16'h8001;
			default: return 16'h8020;
		endcase
	endfunction
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	always @(posedge clk_in) begin
		cyc <= cyc + 1;
		if (cyc == 40000) begin
			n_errors++;
			print_verdict();
		end
	end
	initial begin
		repeat (3) @(posedge clk_in);
		rst_n_in <= 1'b1;
		repeat (2) @(posedge clk_in);
		host.rd(ad(`IOF_IDX_FAULT_ACTION), d, r);
		chk("action", {24'h0, `IOF_FAULT_ACTION_VAL}, d);
		host.rd(ad(`IOF_IDX_WARN_THR), d, r);
		chk("warn_thr", {16'h0, `IOF_WARN_THR_RST}, d);
		host.rd(ad(`IOF_IDX_FAULT_THR), d, r);
		chk("fault_thr", {16'h0, `IOF_FAULT_THR_RST}, d);
		check_all();
		$display("test reset done");
		host.wr(ad(`IOF_IDX_FAULT_ACTION), rnd(), r);
		chk("ro_resp", {30'd0, `IOF_RESP_SLVERR}, {30'd0, r});
		host.rd(12'hffc, d, r);
		chk("unmapped", 32'h0, d);
		chk("unmapped_resp", {30'd0, `IOF_RESP_SLVERR}, {30'd0, r});
		ev(16'h0002, 16'h0000, 1'b1, 1'b0);
		host.rd(ad(`IOF_IDX_FAULT_ACTION), d, r);
		chk("action_kept", {24'h0, `IOF_FAULT_ACTION_VAL}, d);
		check_all();
		clear();
		check_all();
		$display("test bus errors done");
		wthr = {9'd0, 7'(rnd())};
		host.wr(ad(`IOF_IDX_WARN_THR), {16'h0, wthr}, r);
		chk("warn_wr_resp", {30'd0, `IOF_RESP_OKAY}, {30'd0, r});
		host.rd(ad(`IOF_IDX_WARN_THR), d, r);
		chk("warn_rw", {16'h0, wthr}, d);
		for (int i = 0; i < 8; i++) begin
			pulse({8'd0, 8'(rnd())});
			check_all();
		end
		clear();
		$display("test warning done");
		fthr = {5'd1, 11'd128};
		host.wr(ad(`IOF_IDX_FAULT_THR), {16'h0, fthr}, r);
		pulse(16'h0100);
		check_all();
		pulse(16'h0101);
		check_all();
		repeat (200) @(posedge clk_in);
		check_all();
		clear();
		check_all();
		$display("test fault done");
		for (int i = 0; i < 9; i++) begin
			@(posedge clk_in);
			rawv <= 9'h001 << i;
			pg <= i[0];
			@(posedge clk_in);
			rawv <= 9'h000;
			ev(raw_mask(i), 16'h0000, i != 4, 1'b0);
			check_all();
			clear();
		end
		$display("test raw conditions done");
		print_verdict();
	end
endmodule
